// ---- analog_cfg_pkg.sv ----
// Purpose: shared constants and carriers for the analog input configuration and filter block
// Assumes: 20 MHz mclk, parameter record written one byte per cycle
// Notes: times are kept in their own unit, cycle counts derive from them
package analog_cfg_pkg;

    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_MHZ = 20;
    localparam int SAMPLE_RATE_HZ = 1050;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_RATE_HZ;
    localparam int UPDATE_US = 1000;
    localparam int UPDATE_CYC = UPDATE_US * CLK_MHZ;
    localparam int SETTLE_US = 2000;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;

    // integration times in microseconds; the fastest code really runs 1250
    localparam logic [15:0] FAST_INT_US = 16'd1250;
    localparam logic [15:0] MID_INT_US = 16'd16600;
    localparam logic [15:0] SLOW_INT_US = 16'd20000;

    localparam logic [4:0] WIN_50HZ = 5'd19;
    localparam logic [4:0] WIN_60HZ = 5'd16;
    localparam logic [4:0] WIN_NONE = 5'd1;
    localparam int HIST_DEPTH = 19;

    localparam int N_IN = 5;
    localparam int N_OUT = 2;
    localparam int PARM_BYTES = 13;
    localparam int FIFO_DEPTH = 32;

    localparam logic [3:0] IDX_UNIT = 4'h0;
    localparam logic [3:0] IDX_INTEG = 4'h1;
    localparam logic [3:0] IDX_RSVD2 = 4'h2;
    localparam logic [3:0] IDX_IN0 = 4'h3;
    localparam logic [3:0] IDX_IN4 = 4'h7;
    localparam logic [3:0] IDX_RSVD8 = 4'h8;
    localparam logic [3:0] IDX_RSVD10 = 4'ha;
    localparam logic [3:0] IDX_OUT0 = 4'hb;

    localparam logic [7:0] RST_UNIT = 8'h00;
    localparam logic [7:0] RST_INTEG = 8'haa;
    localparam logic [7:0] RST_IN = 8'h19;
    localparam logic [7:0] RST_IN4 = 8'h62;
    localparam logic [7:0] RST_OUT = 8'h19;

    localparam int UNIT_LSB = 3;
    localparam int RANGE_LSB = 0;
    localparam int TYPE_LSB = 4;

    localparam logic [1:0] SUPP_400 = 2'b00;
    localparam logic [1:0] SUPP_60 = 2'b01;
    localparam logic [1:0] SUPP_50 = 2'b10;

    localparam logic [1:0] UNIT_C = 2'b00;
    localparam logic [1:0] UNIT_F = 2'b01;
    localparam logic [1:0] UNIT_K = 2'b10;

    localparam logic [3:0] RNG_OFF = 4'h0;
    localparam logic [3:0] RNG_I0_20 = 4'h2;
    localparam logic [3:0] RNG_I4_20 = 4'h3;
    localparam logic [3:0] RNG_IPM20 = 4'h4;
    localparam logic [3:0] RNG_V0_10 = 4'h8;
    localparam logic [3:0] RNG_VPM10 = 4'h9;
    localparam logic [3:0] RNG_R600 = 4'h2;
    localparam logic [3:0] RNG_RTD = 4'h6;

    localparam logic [3:0] TYP_OFF = 4'h0;
    localparam logic [3:0] TYP_V = 4'h1;
    localparam logic [3:0] TYP_I = 4'h2;
    localparam logic [3:0] TYP_I_ALT = 4'h3;
    localparam logic [3:0] TYP_RES = 4'h6;
    localparam logic [3:0] TYP_RTD = 4'hf;

    localparam logic [15:0] SETTLE_WORD = 16'h7fff;
    localparam logic [20:0] KELVIN_OFS = 21'd2732;
    localparam logic [20:0] FAHR_OFS = 21'd320;

    typedef enum logic [3:0] {
        MODE_OFF, MODE_I0_20, MODE_I4_20, MODE_IPM20, MODE_V0_10,
        MODE_VPM10, MODE_R600, MODE_RTD, MODE_BAD
    } chan_mode_e;

    typedef struct packed {
        logic [2:0] chan;
        logic [15:0] value;
    } raw_sample_s;

    typedef struct packed {
        logic write;
        logic [3:0] index;
        logic [7:0] data;
    } parm_write_s;

endpackage : analog_cfg_pkg

// ---- sample_fifo.sv ----
// Purpose: raw sample buffer between converter and filter
// Assumes: single clock, writer honours wrReady
// Notes: read data come straight from the storage registers
`timescale 1ns/10ps
module sample_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 32
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wrValid,
    input wire logic [WIDTH-1:0] wrData,
    output logic wrReady,
    output logic rdValid,
    output logic [WIDTH-1:0] rdData,
    input wire logic rdReady
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [CW-1:0] count;
        logic full;
        logic empty;
    } fifo_state_s;

    fifo_state_s st;
    fifo_state_s next_st;
    logic doWr;
    logic doRd;

    always_comb begin
        next_st = st;
        doWr = wrValid && !st.full;
        doRd = rdReady && !st.empty;
        if (doWr) begin
            next_st.mem[st.wrPtr] = wrData;
            next_st.wrPtr = (st.wrPtr == PW'(DEPTH - 1)) ? '0 : st.wrPtr + 1'b1;
        end
        if (doRd) begin
            next_st.rdPtr = (st.rdPtr == PW'(DEPTH - 1)) ? '0 : st.rdPtr + 1'b1;
        end
        if (doWr && !doRd) begin
            next_st.count = st.count + 1'b1;
        end else if (doRd && !doWr) begin
            next_st.count = st.count - 1'b1;
        end
        next_st.full = (next_st.count == CW'(DEPTH));
        next_st.empty = (next_st.count == '0);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.empty <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign wrReady = !st.full;
    assign rdValid = !st.empty;
    assign rdData = st.mem[st.rdPtr];

endmodule : sample_fifo

// ---- analog_input_config_filter.sv ----
// Purpose: parameter record, averaging filter and millisecond input words of the analog part
// Assumes: raw samples arrive from converter logic on mclk, channel 4 already in 0.1 deg C
// Notes: history is flip-flops; a write to the record blanks affected words while settling
`timescale 1ns/10ps

module analog_input_config_filter
    import analog_cfg_pkg::*;
#(
    parameter int SAMPLE_CYCLES = SAMPLE_CYC,
    parameter int UPDATE_CYCLES = UPDATE_CYC,
    parameter int SETTLE_CYCLES = SETTLE_CYC,
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire analog_cfg_pkg::parm_write_s parmWr,
    input wire logic rawValid,
    input wire analog_cfg_pkg::raw_sample_s rawIn,
    output logic rawReady,
    output logic sampleReq,
    output logic wordUpdate,
    output logic [analog_cfg_pkg::N_IN-1:0][15:0] inWord,
    output analog_cfg_pkg::chan_mode_e [analog_cfg_pkg::N_IN-1:0] inMode,
    output analog_cfg_pkg::chan_mode_e [analog_cfg_pkg::N_OUT-1:0] outMode,
    output logic [1:0] tempUnit,
    output logic [analog_cfg_pkg::N_IN-2:0][15:0] integUs
);
    import analog_cfg_pkg::*;

    typedef struct packed {
        logic [PARM_BYTES-1:0][7:0] parm;
        logic [N_IN-1:0][HIST_DEPTH-1:0][15:0] hist;
        logic [N_IN-1:0][20:0] sum;
        logic [N_IN-1:0][4:0] cnt;
        logic [N_IN-1:0][4:0] ptr;
        logic [N_IN-1:0][15:0] meas;
        logic [N_IN-1:0][15:0] word;
        logic [15:0] sampCnt;
        logic [15:0] updCnt;
        logic [15:0] settleCnt;
        logic [N_IN-1:0] settleMask;
        logic sampleReq;
        logic wordUpdate;
        logic busy;
        logic [2:0] curCh;
        chan_mode_e [N_IN-1:0] inMode;
        chan_mode_e [N_OUT-1:0] outMode;
        logic [1:0] unit;
        logic [N_IN-2:0][15:0] integUs;
    } state_s;

    state_s st;
    state_s next_st;
    logic fifoValid;
    raw_sample_s fifoData;
    logic fifoRawReady;
    logic [2:0] ch;
    logic [4:0] win;
    logic [15:0] oldVal;
    logic [20:0] quot;
    logic [15:0] mean;
    logic [N_IN-1:0] affect;
    logic settleDone;

    sample_fifo #(
        .WIDTH($bits(raw_sample_s)),
        .DEPTH(BUF_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .wrValid(rawValid),
        .wrData(rawIn),
        .wrReady(fifoRawReady),
        .rdValid(fifoValid),
        .rdData(fifoData),
        .rdReady(!st.busy)
    );

    function automatic logic [4:0] winLen(input logic [1:0] code);
        logic [4:0] w;
        w = WIN_NONE;
        case (code)
            SUPP_50: w = WIN_50HZ;
            SUPP_60: w = WIN_60HZ;
            default: w = WIN_NONE;
        endcase
        return w;
    endfunction : winLen

    function automatic logic [15:0] integTime(input logic [1:0] code);
        logic [15:0] t;
        t = FAST_INT_US;
        case (code)
            SUPP_60: t = MID_INT_US;
            SUPP_50: t = SLOW_INT_US;
            default: t = FAST_INT_US;
        endcase
        return t;
    endfunction : integTime

    function automatic chan_mode_e decodeIn(input logic [7:0] b, input logic isRes);
        logic [3:0] rng;
        logic [3:0] typ;
        chan_mode_e m;
        rng = b[RANGE_LSB +: 4];
        typ = b[TYPE_LSB +: 4];
        m = MODE_BAD;
        if (rng == RNG_OFF || typ == TYP_OFF) begin
            m = MODE_OFF;
        end else if (isRes) begin
            if (typ == TYP_RES && rng == RNG_R600) m = MODE_R600;
            if (typ == TYP_RTD && rng == RNG_RTD) m = MODE_RTD;
        end else if (typ == TYP_V) begin
            if (rng == RNG_V0_10) m = MODE_V0_10;
            if (rng == RNG_VPM10) m = MODE_VPM10;
        end else if (typ == TYP_I || typ == TYP_I_ALT) begin
            if (rng == RNG_I0_20) m = MODE_I0_20;
            if (rng == RNG_I4_20) m = MODE_I4_20;
            if (rng == RNG_IPM20) m = MODE_IPM20;
        end
        return m;
    endfunction : decodeIn

    function automatic chan_mode_e decodeOut(input logic [7:0] b);
        logic [3:0] typ;
        chan_mode_e m;
        typ = b[TYPE_LSB +: 4];
        m = decodeIn({(typ == TYP_I_ALT) ? TYP_I : typ, b[RANGE_LSB +: 4]}, 1'b0);
        if (typ == TYP_I) m = MODE_BAD; // outputs know only 1h and 3h
        return m;
    endfunction : decodeOut

    // temperature arrives in tenths of a degree Celsius
    function automatic logic [15:0] toUnit(input logic [15:0] c, input logic [1:0] u);
        logic [20:0] t;
        t = {{5{c[15]}}, c};
        if (u == UNIT_F) begin
            t = 21'($signed(t) * 21'sd9 / 21'sd5) + FAHR_OFS;
        end else if (u == UNIT_K) begin
            t = t + KELVIN_OFS;
        end
        return t[15:0];
    endfunction : toUnit

    always_comb begin
        next_st = st;
        next_st.sampleReq = 1'b0;
        next_st.wordUpdate = 1'b0;
        ch = fifoData.chan;
        win = WIN_NONE;
        oldVal = '0;
        quot = '0;
        mean = '0;
        affect = '0;
        settleDone = 1'b0;

        // converter pacing and millisecond publish
        if (st.sampCnt == 16'(SAMPLE_CYCLES - 1)) begin
            next_st.sampCnt = '0;
            next_st.sampleReq = 1'b1;
        end else begin
            next_st.sampCnt = st.sampCnt + 16'd1;
        end
        if (st.updCnt == 16'(UPDATE_CYCLES - 1)) begin
            next_st.updCnt = '0;
            next_st.wordUpdate = 1'b1;
            for (int c = 0; c < N_IN; c++) begin
                if (st.settleMask[c]) begin
                    next_st.word[c] = SETTLE_WORD;
                end else if (st.inMode[c] == MODE_OFF || st.inMode[c] == MODE_BAD) begin
                    next_st.word[c] = '0;
                end else begin
                    next_st.word[c] = st.meas[c];
                end
            end
        end else begin
            next_st.updCnt = st.updCnt + 16'd1; // words hold meanwhile
        end

        // second stage: divide the running sum by the samples held
        if (st.busy) begin
            next_st.busy = 1'b0;
            if (st.cnt[st.curCh] != '0) begin
                quot = 21'($signed(st.sum[st.curCh]) / $signed({1'b0, st.cnt[st.curCh]}));
            end
            mean = quot[15:0];
            if (st.curCh == 3'(N_IN - 1) && st.inMode[N_IN-1] == MODE_RTD) begin
                mean = toUnit(mean, st.unit);
            end
            next_st.meas[st.curCh] = mean;
        end else if (fifoValid && ch < 3'(N_IN)) begin
            // first stage: slide the window; busy stalls the buffer for one cycle
            if (ch != 3'(N_IN - 1)) begin
                win = winLen(st.parm[IDX_INTEG][{ch[1:0], 1'b0} +: 2]);
            end
            oldVal = st.hist[ch][st.ptr[ch]];
            if (st.cnt[ch] < win) begin
                next_st.sum[ch] = st.sum[ch] + {{5{fifoData.value[15]}}, fifoData.value};
                next_st.cnt[ch] = st.cnt[ch] + 5'd1;
            end else begin
                next_st.sum[ch] = st.sum[ch] + {{5{fifoData.value[15]}}, fifoData.value}
                    - {{5{oldVal[15]}}, oldVal};
            end
            next_st.hist[ch][st.ptr[ch]] = fifoData.value;
            next_st.ptr[ch] = (st.ptr[ch] + 5'd1 >= win) ? 5'd0 : st.ptr[ch] + 5'd1;
            next_st.busy = 1'b1;
            next_st.curCh = ch;
        end

        // parameter record; reserved bytes are dropped
        if (parmWr.write && parmWr.index < 4'(PARM_BYTES) && parmWr.index != IDX_RSVD2
            && !(parmWr.index >= IDX_RSVD8 && parmWr.index <= IDX_RSVD10)) begin
            next_st.parm[parmWr.index] = parmWr.data;
            if (parmWr.index == IDX_UNIT) begin
                affect[N_IN-1] = 1'b1;
            end else if (parmWr.index == IDX_INTEG) begin
                for (int c = 0; c < N_IN - 1; c++) begin
                    affect[c] = 1'b1;
                    if (parmWr.data[2*c +: 2] != st.parm[IDX_INTEG][2*c +: 2]) begin
                        next_st.cnt[c] = '0;
                        next_st.sum[c] = '0;
                        next_st.ptr[c] = '0;
                    end
                end
            end else if (parmWr.index >= IDX_IN0 && parmWr.index <= IDX_IN4) begin
                affect[3'(parmWr.index - IDX_IN0)] = 1'b1;
            end
        end

        // settle window: a write to the unit, integration or an input byte restarts it and its bits win over expiry
        if (st.settleCnt != '0) begin
            next_st.settleCnt = st.settleCnt - 16'd1;
            settleDone = (st.settleCnt == 16'd1);
        end
        if (affect != '0) begin
            next_st.settleCnt = 16'(SETTLE_CYCLES);
        end
        next_st.settleMask = (settleDone ? '0 : st.settleMask) | affect;

        // decoded views of the record, one cycle behind it
        for (int c = 0; c < N_IN; c++) begin
            next_st.inMode[c] = decodeIn(st.parm[IDX_IN0 + 4'(c)], c == N_IN - 1);
        end
        for (int c = 0; c < N_IN - 1; c++) begin
            next_st.integUs[c] = integTime(st.parm[IDX_INTEG][2*c +: 2]);
        end
        for (int o = 0; o < N_OUT; o++) begin
            next_st.outMode[o] = decodeOut(st.parm[IDX_OUT0 + 4'(o)]);
        end
        next_st.unit = st.parm[IDX_UNIT][UNIT_LSB +: 2];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.parm[IDX_UNIT] <= RST_UNIT;
            st.parm[IDX_INTEG] <= RST_INTEG;
            st.parm[IDX_IN0] <= RST_IN;
            st.parm[IDX_IN0 + 4'd1] <= RST_IN;
            st.parm[IDX_IN0 + 4'd2] <= RST_IN;
            st.parm[IDX_IN0 + 4'd3] <= RST_IN;
            st.parm[IDX_IN4] <= RST_IN4;
            st.parm[IDX_OUT0] <= RST_OUT;
            st.parm[IDX_OUT0 + 4'd1] <= RST_OUT;
            st.inMode <= '{MODE_R600, MODE_VPM10, MODE_VPM10, MODE_VPM10, MODE_VPM10};
            st.outMode <= '{MODE_VPM10, MODE_VPM10};
            st.integUs <= {SLOW_INT_US, SLOW_INT_US, SLOW_INT_US, SLOW_INT_US};
        end else begin
            st <= next_st;
        end
    end

    assign rawReady = fifoRawReady;
    assign sampleReq = st.sampleReq;
    assign wordUpdate = st.wordUpdate;
    assign inWord = st.word;
    assign inMode = st.inMode;
    assign outMode = st.outMode;
    assign tempUnit = st.unit;
    assign integUs = st.integUs;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    AST_SAMPLE_GAP: assert property (sampleReq |=> (!sampleReq) [*8])
        else $error("sample request repeated too soon");
    AST_WORD_HOLD: assert property (!wordUpdate |-> $stable(inWord))
        else $error("input word changed between updates");
    AST_WIN50: assert property (st.parm[IDX_INTEG][1:0] == SUPP_50 && $stable(st.parm)
        |-> st.cnt[0] <= WIN_50HZ)
        else $error("50 Hz window exceeds nineteen");
    AST_WIN60: assert property (st.parm[IDX_INTEG][1:0] == SUPP_60 && $stable(st.parm)
        |-> st.cnt[0] <= WIN_60HZ)
        else $error("60 Hz window exceeds sixteen");
    AST_NOFILT: assert property (st.parm[IDX_INTEG][1:0] == SUPP_400 && $stable(st.parm)
        |-> st.cnt[0] <= WIN_NONE)
        else $error("400 Hz setting averages");
    AST_FULL50: assert property (!st.busy && fifoValid && fifoData.chan == 3'd0
        && st.cnt[0] == WIN_50HZ && st.parm[IDX_INTEG][1:0] == SUPP_50 && !parmWr.write
        |=> st.cnt[0] == WIN_50HZ ##1 !st.busy)
        else $error("full window lost its count");
    AST_FAST_INT: assert property (st.parm[IDX_INTEG][1:0] == SUPP_400
        && $stable(st.parm[IDX_INTEG]) |=> integUs[0] == FAST_INT_US)
        else $error("fast integration time wrong");
    AST_UNIT: assert property (parmWr.write && parmWr.index == IDX_UNIT
        |=> ##1 tempUnit == $past(parmWr.data[4:3], 2))
        else $error("temperature unit not taken");
    AST_SETTLE_SET: assert property (parmWr.write && parmWr.index == IDX_IN0
        |=> st.settleMask[0] && st.settleCnt == 16'(SETTLE_CYCLES))
        else $error("settle window not started");
    AST_SETTLE_CODE: assert property (wordUpdate && $past(st.settleMask[0])
        |-> inWord[0] == SETTLE_WORD)
        else $error("settling word not shown");
    AST_CLEAR: assert property (parmWr.write && parmWr.index == IDX_INTEG
        && parmWr.data[1:0] != st.parm[IDX_INTEG][1:0] |=> st.cnt[0] == 5'd0)
        else $error("history not cleared");
    AST_RSVD: assert property (parmWr.write && parmWr.index == IDX_RSVD2
        |=> st.parm[IDX_RSVD2] == $past(st.parm[IDX_RSVD2]))
        else $error("reserved byte stored");

endmodule : analog_input_config_filter

// ---- sensor_scan_model.sv ----
// Purpose: converter and sensor stand-in that answers scan requests with five samples
// Assumes: drives on the falling edge, holds each sample until rawReady was seen high
// Notes: value is channel times 1000h plus four times the scan number, so means are known
`timescale 1ns/10ps
module sensor_scan_model
    import analog_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic sampleReq,
    input wire logic rawReady,
    output logic rawValid,
    output analog_cfg_pkg::raw_sample_s rawIn
);
    logic took;
    logic start;
    logic [2:0] idx;
    logic [15:0] scan;

    function automatic raw_sample_s mk(input logic [2:0] c, input logic [15:0] n);
        mk.chan = c;
        mk.value = {1'b0, c, 12'h000} + {n[13:0], 2'b00};
    endfunction : mk

    // handshake is judged at the rising edge, changes follow on the falling edge
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            took <= 1'b0;
            start <= 1'b0;
        end else begin
            took <= rawValid & rawReady;
            start <= sampleReq & enable;
        end
    end

    always @(negedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rawValid <= 1'b0;
            idx <= 3'd0;
            scan <= 16'h0000;
            rawIn <= '0;
        end else if (rawValid && took) begin
            if (idx == 3'd4) begin
                // released bus shows the inverse, never a stale copy
                rawValid <= 1'b0;
                scan <= scan + 16'h0001;
                rawIn <= ~rawIn;
            end else begin
                idx <= idx + 3'd1;
                rawIn <= mk(idx + 3'd1, scan);
            end
        end else if (!rawValid && start) begin
            rawValid <= 1'b1;
            idx <= 3'd0;
            rawIn <= mk(3'd0, scan);
        end
    end
endmodule : sensor_scan_model

// ---- analog_input_config_filter_tb.sv ----
// Purpose: self-checking bench for record decode, settling and averaging of the input words
// Assumes: short counts 20/50/100 cycles stand in for sample, update and settle periods
// Notes: scans are gated so each mean is worked out from a known count of samples
`timescale 1ns/10ps
module analog_input_config_filter_tb;
    import analog_cfg_pkg::*;
    localparam int SAMP = 20;
    localparam int UPD = 50;
    localparam int SETL = 100;
    typedef struct packed {
        logic [3:0] idx;
        logic [7:0] data;
        chan_mode_e mode;
    } dec_case_s;
    localparam dec_case_s DEC_TAB [18] = '{
        '{4'h3, 8'h22, MODE_I0_20}, '{4'h3, 8'h33, MODE_I4_20}, '{4'h3, 8'h24, MODE_IPM20},
        '{4'h3, 8'h18, MODE_V0_10}, '{4'h3, 8'h19, MODE_VPM10}, '{4'h3, 8'h12, MODE_BAD},
        '{4'h3, 8'h00, MODE_OFF},
        '{4'h7, 8'h62, MODE_R600}, '{4'h7, 8'hf6, MODE_RTD}, '{4'h7, 8'h00, MODE_OFF},
        '{4'hb, 8'h18, MODE_V0_10}, '{4'hb, 8'h32, MODE_I0_20}, '{4'hb, 8'h34, MODE_IPM20},
        '{4'hb, 8'h00, MODE_OFF}, '{4'hc, 8'h19, MODE_VPM10}, '{4'hc, 8'h33, MODE_I4_20},
        '{4'hc, 8'h22, MODE_BAD}, '{4'hc, 8'h00, MODE_OFF}};
    localparam logic [15:0] EXP_A [5] = '{16'h0030, 16'h1036, 16'h2054, 16'h3054, 16'h4b00};
    localparam logic [15:0] EXP_B [5] = '{16'h005e, 16'h1046, 16'h2064, 16'h3064, 16'h7527};
    localparam logic [3:0] RSVD_IDX [7] = '{4'h2, 4'h8, 4'h9, 4'ha, 4'hd, 4'he, 4'hf};

    logic mclk;
    logic rst_n;
    logic enable;
    parm_write_s parmWr;
    logic rawValid;
    raw_sample_s rawIn;
    logic rawReady;
    logic sampleReq;
    logic wordUpdate;
    logic [N_IN-1:0][15:0] inWord;
    logic [N_IN-1:0][15:0] lastWord;
    chan_mode_e [N_IN-1:0] inMode;
    chan_mode_e [N_OUT-1:0] outMode;
    logic [1:0] tempUnit;
    logic [N_IN-2:0][15:0] integUs;
    int fails;
    int tests_run;
    int gap;

    analog_input_config_filter #(.SAMPLE_CYCLES(SAMP), .UPDATE_CYCLES(UPD),
        .SETTLE_CYCLES(SETL), .BUF_DEPTH(FIFO_DEPTH)) DUT (.mclk(mclk), .rst_n(rst_n),
        .parmWr(parmWr), .rawValid(rawValid), .rawIn(rawIn), .rawReady(rawReady),
        .sampleReq(sampleReq), .wordUpdate(wordUpdate), .inWord(inWord), .inMode(inMode),
        .outMode(outMode), .tempUnit(tempUnit), .integUs(integUs));

    sensor_scan_model partner (.mclk(mclk), .rst_n(rst_n), .enable(enable),
        .sampleReq(sampleReq), .rawReady(rawReady), .rawValid(rawValid), .rawIn(rawIn));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // one byte per strobe; returns once the decoded outputs have landed
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        @(negedge mclk);
        parmWr = '{1'b1, idx, d};
        @(negedge mclk);
        parmWr.write = 1'b0;
        @(negedge mclk);
    endtask : wr

    task automatic pulse_gap(input bit upd, output int n);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (((upd ? wordUpdate : sampleReq) !== 1'b1) && n < 1000);
        if (n >= 1000) check(16'h0, 16'h1);
    endtask : pulse_gap

    // lets exactly k scans start, then waits for the filter and the next publish
    task automatic run_scans(input int k, input logic [15:0] exp [5]);
        int cnt;
        cnt = 0;
        enable = 1'b1;
        for (int g = 0; g < 2000 && cnt < k; g++) begin
            if (sampleReq === 1'b1) cnt++;
            if (cnt < k) @(negedge mclk);
        end
        @(negedge mclk);
        enable = 1'b0;
        repeat (40) @(negedge mclk);
        pulse_gap(1'b1, gap);
        for (int c = 0; c < N_IN; c++) check(inWord[c], exp[c]);
    endtask : run_scans

    always @(negedge mclk) begin
        if (rst_n === 1'b1 && inWord !== lastWord) check(16'(wordUpdate), 16'h1);
        lastWord = inWord;
    end

    initial begin
        #(20000 * 50);
        fails++;
        results();
    end

    initial begin
        parmWr = '0;
        enable = 1'b0;
        rst_n = 1'b0;
        fails = 0;
        tests_run = 0;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        for (int c = 0; c < 4; c++) check(16'(inMode[c]), 16'(MODE_VPM10));
        for (int c = 0; c < 4; c++) check(integUs[c], SLOW_INT_US);
        check(16'(inMode[4]), 16'(MODE_R600));
        check(16'(outMode[0]), 16'(MODE_VPM10));
        check(16'(outMode[1]), 16'(MODE_VPM10));
        check(16'(tempUnit), 16'(UNIT_C));
        pulse_gap(1'b0, gap);
        pulse_gap(1'b0, gap);
        check(16'(gap), 16'(SAMP));
        pulse_gap(1'b1, gap);
        pulse_gap(1'b1, gap);
        check(16'(gap), 16'(UPD));
        wr(IDX_INTEG, 8'h24);
        check(integUs[0], FAST_INT_US);
        check(integUs[1], MID_INT_US);
        check(integUs[2], SLOW_INT_US);
        check(integUs[3], FAST_INT_US);
        for (int u = 2; u >= 0; u--) begin
            wr(IDX_UNIT, 8'he7 | 8'(u << UNIT_LSB));
            check(16'(tempUnit), 16'(u));
        end
        for (int t = 0; t < 18; t++) begin
            wr(DEC_TAB[t].idx, DEC_TAB[t].data);
            check(16'(DEC_TAB[t].idx == IDX_IN0 ? inMode[0] : DEC_TAB[t].idx == IDX_IN4 ?
                inMode[4] : DEC_TAB[t].idx == IDX_OUT0 ? outMode[0] : outMode[1]),
                16'(DEC_TAB[t].mode));
        end
        for (int r = 0; r < 7; r++) wr(RSVD_IDX[r], 8'h19);
        check(16'(inMode[0]), 16'(MODE_OFF));
        check(16'(inMode[4]), 16'(MODE_OFF));
        check(16'(outMode[1]), 16'(MODE_OFF));
        check(16'(tempUnit), 16'(UNIT_C));
        // unconnected outputs stay deactivated from here on
        wr(IDX_IN0, 8'h19);
        wr(IDX_IN4, 8'hf6);
        wr(IDX_UNIT, 8'h10);
        wr(IDX_INTEG, 8'h06);
        pulse_gap(1'b1, gap);
        for (int c = 0; c < N_IN; c++) check(inWord[c], SETTLE_WORD);
        repeat (SETL) @(negedge mclk);
        run_scans(22, EXP_A);
        wr(IDX_INTEG, 8'h05);
        wr(IDX_UNIT, 8'h08);
        repeat (SETL) @(negedge mclk);
        run_scans(4, EXP_B);
        results();
    end
endmodule : analog_input_config_filter_tb
